/* src/sbt_pkg.sv */
// package for the sixteen-bit interval timer: offsets, fields, resets, types
package sbt_pkg;
    // register byte offsets (8-bit data port)
    localparam logic [7:0] OFS_PERIOD_LOW = 8'h10;
    localparam logic [7:0] OFS_PERIOD_HIGH = 8'h11;
    localparam logic [7:0] OFS_CAPTURE_LOW = 8'h12;
    localparam logic [7:0] OFS_CAPTURE_HIGH = 8'h13;
    localparam logic [7:0] OFS_CONTROL = 8'h14;
    localparam logic [7:0] OFS_DIVSEL = 8'h15;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h16;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h17;
    // control field positions
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_CLK_LSB = 2;
    localparam int CTL_RUN_LSB = 4;
    localparam int CTL_ACAP_BIT = 6;
    // reset values
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [15:0] CAPTURE_RESET = 16'hffff;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // field codes
    localparam logic [1:0] RUN_STOP = 2'b00;
    localparam logic [1:0] RUN_START = 2'b01;
    localparam logic [1:0] MODE_TIMER = 2'b00;
    localparam logic [1:0] CLK_RESERVED = 2'b11;
    // divider exponents for source clock codes 00, 01, 10
    localparam int DIV_EXP_SLOW = 11;
    localparam int DIV_EXP_MID = 7;
    localparam int DIV_EXP_FAST = 3;
    localparam int PRESCALE_WIDTH = 13;
    // register port bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sbt_bus_t;
endpackage

/* src/sbt_prescaler.sv */
// prescaler giving a one-cycle source clock enable pulse
`timescale 1ns/10ps
`default_nettype none
module sbt_prescaler #(
    parameter int WIDTH = sbt_pkg::PRESCALE_WIDTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // selection
    input wire logic run,
    input wire logic [1:0] clk_sel,
    input wire logic div_base,
    // output enable pulse
    output logic tick
);
    logic [WIDTH-1:0] count; // divider, cleared while stopped
    logic [WIDTH-1:0] next_count;
    logic [WIDTH-1:0] div_mask; // all-ones below the selected tap
    wire logic [3:0] exp_base;
    wire logic [3:0] exp_sel;

    // pick exponent, doubled division when base select is set
    assign exp_base = (clk_sel == 2'b00) ? 4'(sbt_pkg::DIV_EXP_SLOW) :
                      (clk_sel == 2'b01) ? 4'(sbt_pkg::DIV_EXP_MID) :
                      4'(sbt_pkg::DIV_EXP_FAST);
    assign exp_sel = exp_base + {3'b000, div_base};
    assign div_mask = WIDTH'((1 << exp_sel) - 1);
    assign next_count = run ? count + WIDTH'(1) : '0;

    // divider counts only while running so the first period is whole
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= run && (clk_sel != sbt_pkg::CLK_RESERVED) &&
                    ((count & div_mask) == div_mask);
        end
    end

    // a tick is always separated by at least the fastest division
    a_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst)
        tick |=> !tick [*7]) else $error("source tick too close");
endmodule
`default_nettype wire

/* src/sbt_timer.sv */
// sixteen-bit interval timer with period compare, auto-capture and irq
//
// Summary of operation
// - counter, period, capture sixteen bits, byte split
// - run 00 stops and clears, 01 starts when mode is 00
// - source clock main divided 2^11/2^7/2^3, doubled
// - match raises irq, clears counter, resumes
// - new period commits at next source tick
// - low byte write alone never commits
// - capture copies counter each tick when enabled
// - capture value unsettled after stop/disable
`timescale 1ns/10ps
`default_nettype none
module sbt_timer #(
    parameter int CNT_WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // interrupts
    output logic period_match_irq,
    output logic irq
);
    sbt_pkg::sbt_bus_t bus; // bundled register access
    logic [CNT_WIDTH-1:0] up_count; // running counter
    logic [CNT_WIDTH-1:0] period_compare; // active compare value
    logic [CNT_WIDTH-1:0] period_shadow; // written bytes, not yet active
    logic pending_commit; // high byte written, waiting for a tick
    logic [CNT_WIDTH-1:0] count_capture; // captured counter
    logic [7:0] timer_control; // control byte
    logic divider_base_select; // doubles every division
    logic irq_status; // sticky match flag
    logic irq_mask; // match enable
    wire logic tick;
    wire logic [1:0] run_control;
    wire logic [1:0] source_clock_select;
    wire logic [1:0] operating_mode_select;
    wire logic auto_capture_enable;
    wire logic running;
    wire logic match;
    wire logic wr_low;
    wire logic wr_high;
    wire logic wr_ctl;
    wire logic rd_status;
    wire logic [7:0] next_rdata;
    wire logic [CNT_WIDTH-1:0] next_count;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // control field decode
    assign operating_mode_select = timer_control[sbt_pkg::CTL_MODE_LSB +: 2];
    assign source_clock_select = timer_control[sbt_pkg::CTL_CLK_LSB +: 2];
    assign run_control = timer_control[sbt_pkg::CTL_RUN_LSB +: 2];
    assign auto_capture_enable = timer_control[sbt_pkg::CTL_ACAP_BIT];
    assign running = (run_control == sbt_pkg::RUN_START) &&
                     (operating_mode_select == sbt_pkg::MODE_TIMER);

    // register strobes
    assign wr_low = bus.wr && (bus.addr == sbt_pkg::OFS_PERIOD_LOW);
    assign wr_high = bus.wr && (bus.addr == sbt_pkg::OFS_PERIOD_HIGH);
    assign wr_ctl = bus.wr && (bus.addr == sbt_pkg::OFS_CONTROL);
    assign rd_status = bus.rd && (bus.addr == sbt_pkg::OFS_IRQ_STATUS);

    // compare against the active period, not the shadow
    assign match = running && tick && (up_count == period_compare);
    assign next_count = match ? '0 : up_count + CNT_WIDTH'(1);

    // read data select, unmapped reads as zero
    assign next_rdata =
        (bus.addr == sbt_pkg::OFS_PERIOD_LOW) ? period_compare[7:0] :
        (bus.addr == sbt_pkg::OFS_PERIOD_HIGH) ? period_compare[15:8] :
        (bus.addr == sbt_pkg::OFS_CAPTURE_LOW) ? count_capture[7:0] :
        (bus.addr == sbt_pkg::OFS_CAPTURE_HIGH) ? count_capture[15:8] :
        (bus.addr == sbt_pkg::OFS_CONTROL) ? timer_control :
        (bus.addr == sbt_pkg::OFS_DIVSEL) ? {7'h00, divider_base_select} :
        (bus.addr == sbt_pkg::OFS_IRQ_STATUS) ? {7'h00, irq_status} :
        (bus.addr == sbt_pkg::OFS_IRQ_MASK) ? {7'h00, irq_mask} : 8'h00;

    // source clock enable generation
    sbt_prescaler #(
        .WIDTH(sbt_pkg::PRESCALE_WIDTH)
    ) u_prescaler (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(running),
        .clk_sel(source_clock_select),
        .div_base(divider_base_select),
        .tick(tick)
    );

    // control and configuration registers; bit seven kept as written
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_control <= sbt_pkg::CONTROL_RESET;
            divider_base_select <= 1'b0;
            irq_mask <= 1'b0;
        end else if (bus.wr) begin
            if (wr_ctl) begin
                timer_control <= bus.wdata;
            end
            if (bus.addr == sbt_pkg::OFS_DIVSEL) begin
                divider_base_select <= bus.wdata[0];
            end
            if (bus.addr == sbt_pkg::OFS_IRQ_MASK) begin
                irq_mask <= bus.wdata[0];
            end
        end
    end

    // period shadow: low byte waits, high byte arms the commit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            period_shadow <= sbt_pkg::PERIOD_RESET;
            pending_commit <= 1'b0;
        end else begin
            if (wr_low) begin
                period_shadow[7:0] <= bus.wdata;
            end
            if (wr_high) begin
                period_shadow[15:8] <= bus.wdata;
                pending_commit <= 1'b1;
            end else if (tick) begin
                pending_commit <= 1'b0;
            end
        end
    end

    // active period loads only on the first tick after a high write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            period_compare <= sbt_pkg::PERIOD_RESET;
        end else if (tick && pending_commit) begin
            period_compare <= period_shadow;
        end
    end

    // up-counter: cleared when stopped, advances once per tick
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            up_count <= '0;
        end else if (!running) begin
            up_count <= '0;
        end else if (tick) begin
            up_count <= next_count;
        end
    end

    // capture follows the counter on each tick; stale once disabled
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_capture <= sbt_pkg::CAPTURE_RESET;
        end else if (tick && auto_capture_enable) begin
            count_capture <= up_count;
        end
    end

    // match pulse and sticky status; a new match beats the read clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            period_match_irq <= 1'b0;
            irq_status <= 1'b0;
            irq <= 1'b0;
        end else begin
            period_match_irq <= match;
            irq_status <= match || (irq_status && !rd_status);
            irq <= irq_mask && (match || (irq_status && !rd_status));
        end
    end

    // read data one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= bus.rd ? next_rdata : 8'h00;
        end
    end

    // match clears the counter on that tick
    a_match_clears: assert property (@(posedge clk) disable iff (sys_rst)
        match |=> (up_count == '0)) else $error("counter not cleared");

    // stop clears the counter next cycle
    a_stop_clears: assert property (@(posedge clk) disable iff (sys_rst)
        !running |=> (up_count == '0)) else $error("stopped count nonzero");

    // irq pulse follows a match by one cycle and lasts one cycle
    a_irq_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        match |=> period_match_irq ##1 !period_match_irq)
        else $error("match pulse wrong");

    // while running, the counter moves only on a tick
    a_count_tick: assert property (@(posedge clk) disable iff (sys_rst)
        (!tick && running && $stable(running)) |=> $stable(up_count))
        else $error("count moved without tick");

    // low write alone leaves the active period unchanged
    a_low_only: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_low && !pending_commit && !tick) |=> $stable(period_compare))
        else $error("low byte committed");

    // a tick with a pending commit loads the shadow
    a_commit_tick: assert property (@(posedge clk) disable iff (sys_rst)
        (tick && pending_commit && !wr_low && !wr_high) |=>
        (period_compare == $past(period_shadow)))
        else $error("period not committed");

    // capture copies the counter on an enabled tick
    a_capture_copy: assert property (@(posedge clk) disable iff (sys_rst)
        (tick && auto_capture_enable) |=> (count_capture == $past(up_count)))
        else $error("capture missed");

    // disabled capture holds
    a_capture_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !auto_capture_enable |=> $stable(count_capture))
        else $error("capture changed while off");

    // a tick without a match steps the counter by exactly one
    a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
        (running && tick && !match) |=> (up_count == $past(up_count) + CNT_WIDTH'(1)))
        else $error("count step wrong");

    // ticks come only from a prescaler that was running
    a_tick_running: assert property (@(posedge clk) disable iff (sys_rst)
        tick |-> $past(running)) else $error("tick while stopped");

    // the reserved clock code never produces a tick
    a_reserved_clock: assert property (@(posedge clk) disable iff (sys_rst)
        (source_clock_select == sbt_pkg::CLK_RESERVED) |=> !tick)
        else $error("tick from reserved clock");

    // a high byte write arms the commit
    a_high_arms: assert property (@(posedge clk) disable iff (sys_rst)
        wr_high |=> pending_commit) else $error("commit not armed");

    // a tick without a fresh high write disarms the commit
    a_commit_drops: assert property (@(posedge clk) disable iff (sys_rst)
        (tick && !wr_high) |=> !pending_commit) else $error("commit left armed");

    // the active period moves only on a tick
    a_period_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !tick |=> $stable(period_compare)) else $error("period moved off tick");

    // capture moves only on a tick
    a_capture_tick: assert property (@(posedge clk) disable iff (sys_rst)
        !tick |=> $stable(count_capture)) else $error("capture moved off tick");

    // capture bytes ignore writes
    a_capture_ro: assert property (@(posedge clk) disable iff (sys_rst)
        (bus.wr && !tick && ((bus.addr == sbt_pkg::OFS_CAPTURE_LOW) ||
        (bus.addr == sbt_pkg::OFS_CAPTURE_HIGH))) |=> $stable(count_capture))
        else $error("capture written");

    // read data falls to zero after a cycle without a read
    a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !bus.rd |=> (reg_rdata == 8'h00)) else $error("read data not idle");

    // period high byte reads back the active value
    a_rdata_period: assert property (@(posedge clk) disable iff (sys_rst)
        (bus.rd && (bus.addr == sbt_pkg::OFS_PERIOD_HIGH)) |=>
        (reg_rdata == $past(period_compare[15:8]))) else $error("period read wrong");

    // capture low byte reads back the captured count
    a_rdata_capture: assert property (@(posedge clk) disable iff (sys_rst)
        (bus.rd && (bus.addr == sbt_pkg::OFS_CAPTURE_LOW)) |=>
        (reg_rdata == $past(count_capture[7:0]))) else $error("capture read wrong");

    // a match sets the sticky status
    a_status_set: assert property (@(posedge clk) disable iff (sys_rst)
        match |=> irq_status) else $error("status not set");

    // status stays until it is read
    a_status_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (irq_status && !rd_status) |=> irq_status) else $error("status lost");

    // a status read clears it unless a match lands with it
    a_status_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_status && !match) |=> !irq_status) else $error("status not cleared");

    // the level interrupt is status behind the mask
    a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> (irq == ($past(irq_mask) && irq_status))) else $error("irq level wrong");

    // a control write lands as written
    a_ctl_write: assert property (@(posedge clk) disable iff (sys_rst)
        wr_ctl |=> (timer_control == $past(bus.wdata))) else $error("control not written");
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the sixteen-bit interval timer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // design ports
    logic clk;
    logic sys_rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic period_match_irq;
    logic irq;
    // bench state
    int mismatches;
    int n_compared;
    logic [7:0] d;
    int n;
    int p;
    int dv;
    int ex;

    sbt_timer uut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .period_match_irq(period_match_irq), .irq(irq)
    );

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // verdict and end of run
    task automatic wrap_up;
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // compare a byte or flag
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare a measured cycle count
    task automatic cmp_int(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle register read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // bounded wait for a match pulse, then check it lasts one cycle
    task automatic pulse(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1 cnt++;
        end while (period_match_irq !== 1'b1 && cnt < lim);
        if (period_match_irq !== 1'b1) begin
            mismatches++;
            wrap_up();
        end else begin
            @(posedge clk);
            #1 cmp8({7'h0, period_match_irq}, 8'h00);
        end
    endtask

    // main sequence
    initial begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mismatches = 0;
        n_compared = 0;
        void'($urandom(32'he80e));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        // reset values, read-only capture, unmapped place
        rd(sbt_pkg::OFS_PERIOD_HIGH, d);
        cmp8(d, sbt_pkg::PERIOD_RESET[15:8]);
        wr(sbt_pkg::OFS_CAPTURE_LOW, 8'h55);
        rd(sbt_pkg::OFS_CAPTURE_LOW, d);
        cmp8(d, sbt_pkg::CAPTURE_RESET[7:0]);
        rd(sbt_pkg::OFS_CONTROL, d);
        cmp8(d, sbt_pkg::CONTROL_RESET);
        rd(8'h20, d);
        cmp8(d, 8'h00);
        // low byte alone, then high byte while stopped: no commit yet
        wr(sbt_pkg::OFS_PERIOD_LOW, 8'h03);
        rd(sbt_pkg::OFS_PERIOD_LOW, d);
        cmp8(d, 8'hff);
        wr(sbt_pkg::OFS_PERIOD_HIGH, 8'h00);
        rd(sbt_pkg::OFS_PERIOD_LOW, d);
        cmp8(d, 8'hff);
        // source clock codes 00, 01 and 10 with both divider bases
        for (int c = 0; c < 3; c++) begin
            for (int ds = 0; ds < 2; ds++) begin
                wr(sbt_pkg::OFS_CONTROL, 8'h00);
                wr(sbt_pkg::OFS_DIVSEL, 8'(ds));
                p = (c == 0) ? 2 : 2 + ($urandom % 6);
                wr(sbt_pkg::OFS_PERIOD_LOW, 8'(p));
                wr(sbt_pkg::OFS_PERIOD_HIGH, 8'h00);
                ex = (c == 0) ? sbt_pkg::DIV_EXP_SLOW :
                     (c == 1) ? sbt_pkg::DIV_EXP_MID : sbt_pkg::DIV_EXP_FAST;
                dv = 1 << (ex + ds);
                // clock chosen while stopped, then started on its own
                wr(sbt_pkg::OFS_CONTROL, {2'b00, sbt_pkg::RUN_STOP, 2'(c), 2'b00});
                wr(sbt_pkg::OFS_CONTROL, {2'b00, sbt_pkg::RUN_START, 2'(c), 2'b00});
                rd(sbt_pkg::OFS_CONTROL, d);
                cmp8(d, {2'b00, sbt_pkg::RUN_START, 2'(c), 2'b00});
                // first match: commit on the first tick, p + 1 ticks in all
                pulse((p + 1) * dv + 20, n);
                cmp_int(n + 1, (p + 1) * dv);
                rd(sbt_pkg::OFS_PERIOD_LOW, d);
                cmp8(d, 8'(p));
                // pulse waits from three cycles after the previous match
                pulse((p + 1) * dv + 20, n);
                cmp_int(n + 3, (p + 1) * dv);
                cmp8({7'h0, irq}, 8'h00);
            end
        end
        // capture disabled keeps its value, enabled follows the counter
        wr(sbt_pkg::OFS_CONTROL, 8'h00);
        wr(sbt_pkg::OFS_DIVSEL, 8'h00);
        wr(sbt_pkg::OFS_PERIOD_LOW, 8'h40);
        wr(sbt_pkg::OFS_PERIOD_HIGH, 8'h00);
        wr(sbt_pkg::OFS_CONTROL, 8'h08);
        wr(sbt_pkg::OFS_CONTROL, 8'h18);
        // pulse starts right after the start write: one cycle more
        pulse(600, n);
        cmp_int(n - 1, 65 << sbt_pkg::DIV_EXP_FAST);
        rd(sbt_pkg::OFS_CAPTURE_LOW, d);
        cmp8(d, 8'hff);
        wr(sbt_pkg::OFS_CONTROL, 8'h58);
        pulse(600, n);
        repeat (24) @(posedge clk);
        rd(sbt_pkg::OFS_CAPTURE_LOW, d);
        cmp8({7'h0, d === 8'h02 || d === 8'h03}, 8'h01);
        rd(sbt_pkg::OFS_CAPTURE_HIGH, d);
        cmp8(d, 8'h00);
        // sticky status, mask, clear on read
        wr(sbt_pkg::OFS_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        #1 cmp8({7'h0, irq}, 8'h01);
        wr(sbt_pkg::OFS_CONTROL, 8'h00);
        rd(sbt_pkg::OFS_IRQ_STATUS, d);
        cmp8(d, 8'h01);
        repeat (2) @(posedge clk);
        #1 cmp8({7'h0, irq}, 8'h00);
        rd(sbt_pkg::OFS_IRQ_STATUS, d);
        cmp8(d, 8'h00);
        // reserved mode, then reserved clock code: no match in 600 cycles
        for (int k = 0; k < 2; k++) begin
            wr(sbt_pkg::OFS_CONTROL, (k == 0) ? 8'h09 : 8'h0c);
            wr(sbt_pkg::OFS_CONTROL, (k == 0) ? 8'h19 : 8'h1c);
            repeat (600) @(posedge clk);
            wr(sbt_pkg::OFS_CONTROL, 8'h00);
            rd(sbt_pkg::OFS_IRQ_STATUS, d);
            cmp8(d, 8'h00);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
